// [pfs_pkg.sv]
package pfs_pkg;
  localparam logic [7:0] PFS_WARN_VECTOR = 8'h2b;
  localparam int PFS_SYNC_STAGES = 3;
  localparam int PFS_CMP_STAGES = 2;
  localparam logic PFS_STROBE_IDLE = 1'h1;
  localparam logic PFS_IND_ASSERTED = 1'h0;
  localparam logic PFS_RST_ASSERTED = 1'h1;
  localparam int PFS_NUM_ENABLES = 3;
  typedef enum logic [2:0] {
    PFS_NORMAL,
    PFS_WARNING,
    PFS_LOW_RESET,
    PFS_BACKUP
  } pfs_state_type;
endpackage

// [pfs_sync.sv]
module pfs_sync #(
  parameter int STAGES = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  input wire logic reset_val,
  output logic sync_out,
  output logic sync_prev
);
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;

  always_comb begin
    chain_next = {chain_reg[STAGES-2:0], async_in};
  end

  // Reset value is a constant per instance so the chain never holds a port value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign sync_out = chain_reg[STAGES-1] ^ reset_val;
  assign sync_prev = chain_reg[STAGES-2] ^ reset_val;
endmodule

// [power_fail_sequencer.sv]
module pfs_power_fail_sequencer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic warning_threshold,
  input wire logic min_operating_threshold,
  input wire logic battery_switch_threshold,
  input wire logic warn_enable,
  input wire logic warn_irq_ack,
  input wire logic [pfs_pkg::PFS_NUM_ENABLES-1:0] core_enables_n,
  input wire logic core_write_n,
  input wire logic supply_reset_line_n_in,
  output logic supply_reset_line_n_out,
  output logic supply_reset_line_n_oe,
  output logic backup_active_n,
  output logic warn_irq,
  output logic [7:0] warn_irq_vector,
  output logic core_reset,
  output logic circuits_enable,
  output logic [pfs_pkg::PFS_NUM_ENABLES-1:0] enables_n,
  output logic write_n,
  output pfs_pkg::pfs_state_type state
);
  import pfs_pkg::*;

  logic warn_s, min_s, bat_s;
  logic line_s, line_p;
  logic line_low;
  pfs_state_type state_reg, state_next;
  logic warn_irq_reg, warn_irq_next;
  logic warn_seen_reg, warn_seen_next;
  logic core_reset_reg, core_reset_next;
  logic ind_low_reg, ind_low_next;
  logic bak_reg, bak_next;
  logic [PFS_NUM_ENABLES-1:0] en_reg, en_next;
  logic wr_reg, wr_next;

  // Both low-supply states hold the core and pull the shared line
  function automatic logic in_low_supply(input pfs_state_type s);
    return (s == PFS_LOW_RESET) || (s == PFS_BACKUP);
  endfunction

  // Comparator outputs are high while supply is below each level
  pfs_sync #(
    .STAGES(PFS_CMP_STAGES)
  ) u_warn (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(warning_threshold),
    .reset_val(1'h0),
    .sync_out(warn_s),
    .sync_prev()
  );

  pfs_sync #(
    .STAGES(PFS_CMP_STAGES)
  ) u_min (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(min_operating_threshold),
    .reset_val(1'h0),
    .sync_out(min_s),
    .sync_prev()
  );

  pfs_sync #(
    .STAGES(PFS_CMP_STAGES)
  ) u_bat (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(battery_switch_threshold),
    .reset_val(1'h0),
    .sync_out(bat_s),
    .sync_prev()
  );

  // Line pin: three stages, inverted storage so reset reads as released high
  pfs_sync #(
    .STAGES(PFS_SYNC_STAGES)
  ) u_line (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(~supply_reset_line_n_in),
    .reset_val(1'h0),
    .sync_out(line_s),
    .sync_prev(line_p)
  );

  // Change counts only once second and third stage agree
  logic line_low_reg, line_low_next;
  logic [PFS_SYNC_STAGES:0] echo_reg, echo_next;
  logic echo_mask;

  always_comb begin
    line_low_next = line_low_reg;
    if (line_s == line_p) begin
      line_low_next = line_s;
    end
    echo_next = {echo_reg[PFS_SYNC_STAGES-1:0], ind_low_reg};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_low_reg <= 1'h0;
      echo_reg <= '0;
    end else begin
      line_low_reg <= line_low_next;
      echo_reg <= echo_next;
    end
  end

  // Own drive reads back low and echoes through the synchroniser after release;
  // masking that tail avoids a second reset pulse when the supply recovers.
  // Limitation: a foreign pull that starts under our drive counts after the tail.
  assign echo_mask = ind_low_reg | (|echo_reg);
  assign line_low = line_low_reg & ~echo_mask;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PFS_NORMAL: begin
        if (bat_s) state_next = PFS_BACKUP;
        else if (min_s) state_next = PFS_LOW_RESET;
        else if (warn_s) state_next = PFS_WARNING;
      end
      PFS_WARNING: begin
        if (bat_s) state_next = PFS_BACKUP;
        else if (min_s) state_next = PFS_LOW_RESET;
        else if (!warn_s) state_next = PFS_NORMAL;
      end
      PFS_LOW_RESET: begin
        if (bat_s) state_next = PFS_BACKUP;
        else if (!min_s) state_next = warn_s ? PFS_WARNING : PFS_NORMAL;
      end
      PFS_BACKUP: begin
        if (!bat_s) begin
          if (min_s) state_next = PFS_LOW_RESET;
          else state_next = warn_s ? PFS_WARNING : PFS_NORMAL;
        end
      end
      default: state_next = PFS_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PFS_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    // Warning touches only the interrupt; the core keeps running
    warn_seen_next = warn_s;
    warn_irq_next = warn_irq_reg;
    if (warn_irq_ack) begin
      warn_irq_next = 1'h0;
    end
    // Set after the clear, so a new warning edge beats an ack
    if (warn_s && !warn_seen_reg && warn_enable) begin
      warn_irq_next = 1'h1;
    end
    if (in_low_supply(state_next)) begin
      warn_irq_next = 1'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      warn_irq_reg <= 1'h0;
      warn_seen_reg <= 1'h0;
    end else begin
      warn_irq_reg <= warn_irq_next;
      warn_seen_reg <= warn_seen_next;
    end
  end

  always_comb begin
    core_reset_next = in_low_supply(state_next) || line_low;
    ind_low_next = in_low_supply(state_next);
    bak_next = (state_next == PFS_BACKUP);
  end

  // External reset pin holds the core in reset and parks the strobes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_reset_reg <= PFS_RST_ASSERTED;
      ind_low_reg <= 1'h0;
      bak_reg <= 1'h0;
    end else begin
      core_reset_reg <= core_reset_next;
      ind_low_reg <= ind_low_next;
      bak_reg <= bak_next;
    end
  end

  always_comb begin
    en_next = core_enables_n;
    wr_next = core_write_n;
    if (core_reset_next) begin
      en_next = {PFS_NUM_ENABLES{PFS_STROBE_IDLE}};
      wr_next = PFS_STROBE_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_reg <= {PFS_NUM_ENABLES{PFS_STROBE_IDLE}};
      wr_reg <= PFS_STROBE_IDLE;
    end else begin
      en_reg <= en_next;
      wr_reg <= wr_next;
    end
  end

  // Indicator logic sits in the battery domain so it holds at zero supply
  assign supply_reset_line_n_out = PFS_IND_ASSERTED;
  assign supply_reset_line_n_oe = ind_low_reg;
  assign backup_active_n = ~bak_reg;
  assign circuits_enable = ~bak_reg;
  assign warn_irq = warn_irq_reg;
  assign warn_irq_vector = PFS_WARN_VECTOR;
  assign core_reset = core_reset_reg | rst;
  assign enables_n = en_reg;
  assign write_n = wr_reg;
  assign state = state_reg;
endmodule

// [pfs_assertions.sv]
module pfs_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic warning_threshold,
  input wire logic warn_enable,
  input wire logic min_operating_threshold,
  input wire logic battery_switch_threshold,
  input wire logic supply_reset_line_n_in,
  input wire logic supply_reset_line_n_oe,
  input wire logic backup_active_n,
  input wire logic warn_irq,
  input wire logic core_reset,
  input wire logic write_n,
  input wire logic [7:0] warn_irq_vector,
  input wire logic [pfs_pkg::PFS_NUM_ENABLES-1:0] enables_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;
  wire logic wn = warning_threshold;
  wire logic en = warn_enable;
  wire logic lo = min_operating_threshold;
  wire logic bt = battery_switch_threshold;
  wire logic ln = supply_reset_line_n_in;
  wire logic oe = supply_reset_line_n_oe;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_min_reset: assert property (lo [*4] |-> core_reset) else $error("no reset");
  chk_line_drive: assert property (lo [*4] |-> oe) else $error("line free");
  chk_line_free: assert property ((!lo) [*4] |-> !oe) else $error("line held");
  chk_backup_flag: assert property (bt [*4] |-> !backup_active_n) else $error("no flag");
  chk_foreign_pull: assert property ((!ln && !oe) [*7] |-> core_reset)
    else $error("pull ignored");
  chk_no_halt: assert property ((!lo && ln) [*7] |-> !core_reset) else $error("halt");
  chk_strobe_idle: assert property (core_reset |-> &{enables_n, write_n})
    else $error("strobe active");
  chk_warn_vector: assert property (warn_irq |-> warn_irq_vector == 8'h2b)
    else $error("bad vector");
  chk_warn_raise: assert property ($rose(wn) && en && !lo && !bt ##1
    (wn && en && !lo && !bt) [*3] |-> warn_irq) else $error("no warning irq");
  cover property (core_reset && !oe);
  cover property (!backup_active_n);
  cover property (warn_irq);
endmodule
bind pfs_power_fail_sequencer pfs_checker chk_u (
  .core_clk(core_clk),
  .rst(rst),
  .warning_threshold(warning_threshold),
  .warn_enable(warn_enable),
  .min_operating_threshold(min_operating_threshold),
  .battery_switch_threshold(battery_switch_threshold),
  .supply_reset_line_n_in(supply_reset_line_n_in),
  .supply_reset_line_n_oe(supply_reset_line_n_oe),
  .backup_active_n(backup_active_n),
  .warn_irq(warn_irq),
  .core_reset(core_reset),
  .write_n(write_n),
  .warn_irq_vector(warn_irq_vector),
  .enables_n(enables_n)
);

// [pfs_line_model.sv]
module pfs_line_model (
  input wire logic dut_oe,
  input wire logic dut_out,
  input wire logic other_pull,
  output logic line_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pullup wins only while no party pulls
  assign line_n = (dut_oe ? dut_out : 1'h1) & !other_pull;
endmodule

// [tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1, warning_threshold, min_operating_threshold, pull;
  logic battery_switch_threshold, warn_enable, warn_irq_ack, supply_reset_line_n_in;
  logic supply_reset_line_n_oe, supply_reset_line_n_out, backup_active_n, warn_irq;
  logic core_reset, circuits_enable, write_n;
  logic [7:0] warn_irq_vector;
  logic [PFS_NUM_ENABLES-1:0] enables_n;
  logic [PFS_NUM_ENABLES-1:0] core_enables_n = 3'h5;
  logic core_write_n = 1'h0;
  pfs_state_type state;
  int fail_count = 0, total_checks = 0, cyc = 0;
  pfs_line_model pm_u (.dut_oe(supply_reset_line_n_oe), .dut_out(supply_reset_line_n_out),
    .other_pull(pull), .line_n(supply_reset_line_n_in));
  pfs_power_fail_sequencer dut_u (
    .core_clk(core_clk),
    .rst(rst),
    .warning_threshold(warning_threshold),
    .min_operating_threshold(min_operating_threshold),
    .battery_switch_threshold(battery_switch_threshold),
    .warn_enable(warn_enable),
    .warn_irq_ack(warn_irq_ack),
    .core_enables_n(core_enables_n),
    .core_write_n(core_write_n),
    .supply_reset_line_n_in(supply_reset_line_n_in),
    .supply_reset_line_n_out(supply_reset_line_n_out),
    .supply_reset_line_n_oe(supply_reset_line_n_oe),
    .backup_active_n(backup_active_n),
    .warn_irq(warn_irq),
    .warn_irq_vector(warn_irq_vector),
    .core_reset(core_reset),
    .circuits_enable(circuits_enable),
    .enables_n(enables_n),
    .write_n(write_n),
    .state(state)
  );
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 400) print_verdict();
  task automatic drive(input logic [5:0] v, input int n);
    {warn_enable, warn_irq_ack, warning_threshold, min_operating_threshold,
      battery_switch_threshold, pull} = v;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    fail_count += (g !== e);
  endtask
  task automatic print_verdict();
    fail_count += (cyc >= 400);
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_warn();
    drive(6'h28, 4);
    chk("warn_irq", 1'h1, warn_irq);
    chk("vector", 8'h2b, warn_irq_vector);
    chk("core_reset", 1'h0, core_reset);
    chk("strobes", 4'ha, {enables_n, write_n});
    chk("state", PFS_WARNING, state);
    drive(6'h38, 1);
    chk("warn_irq", 1'h0, warn_irq);
    drive(6'h00, 4);
    drive(6'h08, 6);
    chk("warn_irq", 1'h0, warn_irq);
    $display("warn test done");
  endtask
  task automatic t_supply();
    drive(6'h0c, 4);
    chk("core_reset", 1'h1, core_reset);
    chk("strobes", 4'hf, {enables_n, write_n});
    chk("line", 1'h0, supply_reset_line_n_in);
    chk("state", PFS_LOW_RESET, state);
    drive(6'h0e, 4);
    chk("backup_n", 1'h0, backup_active_n);
    chk("state", PFS_BACKUP, state);
    chk("circuits", 1'h0, circuits_enable);
    chk("line", 1'h0, supply_reset_line_n_in);
    drive(6'h00, 4);
    chk("core_reset", 1'h0, core_reset);
    chk("backup_n", 1'h1, backup_active_n);
    chk("circuits", 1'h1, circuits_enable);
    chk("state", PFS_NORMAL, state);
    $display("supply test done");
  endtask
  task automatic t_foreign();
    drive(6'h01, 7);
    chk("core_reset", 1'h1, core_reset);
    drive(6'h00, 7);
    chk("core_reset", 1'h0, core_reset);
    rst = 1'h1;
    drive(6'h00, 1);
    chk("core_reset", 1'h1, core_reset);
    chk("strobes", 4'hf, {enables_n, write_n});
    rst = 1'h0;
    $display("foreign test done");
  endtask
  initial begin
    drive(6'h00, 4);
    rst = 1'h0;
    t_warn();
    t_supply();
    t_foreign();
    print_verdict();
  end
endmodule
